// ==== hdl/asc_pkg.sv ====
// constants for the converter sequence controller: register map, fields, resets, timing
// assumes a 32-bit apb slave on a single 125 MHz clock, asynchronous active-low reset
// Overview of operation
// - resolution bit: 0 is 8-bit, 1 is 10-bit
// - final sample lasts 2/4/8/16 converter clocks
// - bus clock divided by prescale+1, then by two
// - prescale field resets to 00001, divide by four
// - timing control write aborts running sequence immediately
// - timing or sequence control write starts sequence, clears flags
// - length bits give 4, 1 or 8 conversions
// - normal mode: nth result into register n-1
// - fifo mode: result index continues and wraps
// - scan off: one sequence, flag, then idle
// - scan on: flag each sequence, restart at once
// - single channel: all conversions on selected code
// - multi channel: code increments per conversion
// - special bit converts internal references, codes 100-110
// - channel code wraps from maximum to minimum
// - conversion flag n set when result stored
package asc_pkg;
   // ===========================================================
   // register byte addresses
   localparam logic [7:0] ASC_OFF_TIMING = 8'h00;
   localparam logic [7:0] ASC_OFF_SEQ = 8'h04;
   localparam logic [7:0] ASC_OFF_MODE = 8'h08;
   localparam logic [7:0] ASC_OFF_STATUS = 8'h0C;
   localparam logic [7:0] ASC_OFF_RESULT0 = 8'h20;
   localparam logic [7:0] ASC_OFF_RESULT7 = 8'h3C;
   // ===========================================================
   // timing control fields
   localparam int ASC_RES_BIT = 7;
   localparam int ASC_SMP_LSB = 5;
   localparam int ASC_PRS_LSB = 0;
   localparam logic [7:0] ASC_TIMING_RESET = 8'h01;
   // sequence control fields
   localparam int ASC_EIGHT_BIT = 6;
   localparam int ASC_SCAN_BIT = 5;
   localparam int ASC_MULTI_CHANNEL_BIT_BIT = 4;
   localparam int ASC_SPECIAL_BIT = 3;
   localparam int ASC_CODE_LSB = 0;
   localparam logic [7:0] ASC_SEQ_RESET = 8'h00;
   // mode control fields
   localparam int ASC_ONE_BIT = 0;
   localparam int ASC_FIFO_BIT = 1;
   localparam logic [7:0] ASC_MODE_RESET = 8'h00;
   // status fields
   localparam int ASC_STAT_SCF_BIT = 15;
   localparam int ASC_STAT_CNT_LSB = 8;
   // ===========================================================
   // timing counts in converter clock periods
   localparam logic [4:0] ASC_BUF_SAMPLE_CLKS = 5'h02;
   localparam logic [4:0] ASC_CONV_CLKS_8 = 5'h08;
   localparam logic [4:0] ASC_CONV_CLKS_10 = 5'h0A;
   localparam logic [4:0] ASC_FINAL_2 = 5'h02;
   localparam logic [4:0] ASC_FINAL_4 = 5'h04;
   localparam logic [4:0] ASC_FINAL_8 = 5'h08;
   localparam logic [4:0] ASC_FINAL_16 = 5'h10;
   // ===========================================================
   // sequencer states
   typedef enum logic [3:0] {
      ASC_IDLE = 4'h1,
      ASC_BUF = 4'h2,
      ASC_FINAL = 4'h4,
      ASC_CONV = 4'h8
   } asc_state_t;
endpackage

// ==== hdl/asc_clk_if.sv ====
// carrier between the sequencer and its converter clock prescaler
// assumes both ends run on sys_clk
`timescale 1ns/1ns
`default_nettype none
interface asc_clk_if;
   logic [4:0] prescale;
   logic restart;
   logic ad_tick;
   modport ctrl (output prescale, output restart, input ad_tick);
   modport div (input prescale, input restart, output ad_tick);
endinterface
`default_nettype wire

// ==== hdl/asc_prescaler.sv ====
// converter clock prescaler: emits one-cycle ticks at sys_clk / (2 * (prescale + 1))
// assumes prescale and restart come from logic on sys_clk
`timescale 1ns/1ns
`default_nettype none
module asc_prescaler
   import asc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   asc_clk_if.div clk_bus
);
   logic [4:0] mod_cnt;
   logic half;
   logic [4:0] next_mod_cnt;
   logic next_half;
   logic wrap;

   // ===========================================================
   // modulus counter then divide by two
   always_comb begin
      wrap = (mod_cnt == clk_bus.prescale);
      next_mod_cnt = wrap ? 5'h00 : mod_cnt + 5'h01;
      next_half = wrap ? ~half : half;
      // restart realigns the phase so a new setting applies at once
      if (clk_bus.restart) begin
         next_mod_cnt = 5'h00;
         next_half = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mod_cnt <= 5'h00;
         half <= 1'b0;
      end else begin
         mod_cnt <= next_mod_cnt;
         half <= next_half;
      end
   end

   // a tick on every second wrap gives the total divisor
   assign clk_bus.ad_tick = wrap & half & ~clk_bus.restart;
endmodule // asc_prescaler
`default_nettype wire

// ==== hdl/asc_sequencer.sv ====
// converter sequence controller: apb registers, sequencing and result storage
// assumes the analog side follows the phase strobes and presents its result
// on adc_result_data by the end of the conversion phase
`timescale 1ns/1ns
`default_nettype none
module asc_sequencer
   import asc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] adc_result_data,
   output logic ad_clk_tick,
   output logic sample_buffered,
   output logic sample_final,
   output logic convert_active,
   output logic convert_ten_bit,
   output logic special_channel_bit,
   output logic [2:0] channel_select,
   output logic sequence_busy
);
   import asc_pkg::*;

   // ===========================================================
   // helpers
   function automatic logic [4:0] final_clks(input logic [1:0] code);
      unique case (code)
         2'b00: final_clks = ASC_FINAL_2;
         2'b01: final_clks = ASC_FINAL_4;
         2'b10: final_clks = ASC_FINAL_8;
         2'b11: final_clks = ASC_FINAL_16;
      endcase
   endfunction

   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == ASC_OFF_TIMING) || (addr == ASC_OFF_SEQ) ||
         (addr == ASC_OFF_MODE) || (addr == ASC_OFF_STATUS) ||
         ((addr >= ASC_OFF_RESULT0) && (addr <= ASC_OFF_RESULT7) && (addr[1:0] == 2'b00));
   endfunction

   // ===========================================================
   // state
   logic [7:0] timing_control;
   logic [7:0] sequence_control;
   logic [7:0] mode_control;
   logic [9:0] result_file [0:7];
   asc_state_t state;
   logic [4:0] phase_cnt;
   logic [2:0] seq_pos;
   logic [2:0] res_ptr;
   logic [2:0] cur_code;
   logic sequence_complete_flag;
   logic [7:0] conversion_complete_flags;
   logic [9:0] sync_a;
   logic [9:0] sync_b;
   logic [31:0] rd_data;
   logic [7:0] next_timing_control;
   logic [7:0] next_sequence_control;
   logic [7:0] next_mode_control;
   asc_state_t next_state;
   logic [4:0] next_phase_cnt;
   logic [2:0] next_seq_pos;
   logic [2:0] next_res_ptr;
   logic [2:0] next_cur_code;
   logic next_sequence_complete_flag;
   logic [7:0] next_conversion_complete_flags;
   logic [31:0] next_rd_data;
   logic store_en;
   logic setup;
   logic wr_access;
   logic wr_timing;
   logic wr_seq;
   logic start_seq;
   logic [2:0] last_pos;
   logic [4:0] conv_clks;
   logic tick;

   asc_clk_if clk_bus ();

   asc_prescaler u_prescaler (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .clk_bus (clk_bus)
   );

   // ===========================================================
   // bus decode: zero wait states, read data captured in the setup cycle
   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite & mapped(paddr);
   assign wr_timing = wr_access && (paddr == ASC_OFF_TIMING);
   assign wr_seq = wr_access && (paddr == ASC_OFF_SEQ);
   assign start_seq = wr_timing | wr_seq;
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped(paddr);
   assign prdata = rd_data;

   // converter clock follows the newest timing value and restarts with a sequence
   assign clk_bus.prescale = timing_control[ASC_PRS_LSB +: 5];
   assign clk_bus.restart = start_seq;
   assign tick = clk_bus.ad_tick;

   // 8-bit needs fewer approximation steps
   assign conv_clks = timing_control[ASC_RES_BIT] ? ASC_CONV_CLKS_10 : ASC_CONV_CLKS_8;

   // sequence length coding, eight-length takes precedence
   always_comb begin
      if (sequence_control[ASC_EIGHT_BIT]) begin
         last_pos = 3'h7;
      end else if (mode_control[ASC_ONE_BIT]) begin
         last_pos = 3'h0;
      end else begin
         last_pos = 3'h3;
      end
   end

   // ===========================================================
   // register file next values
   always_comb begin
      next_timing_control = timing_control;
      next_sequence_control = sequence_control;
      next_mode_control = mode_control;
      next_rd_data = rd_data;
      if (wr_timing) begin
         next_timing_control = pwdata[7:0];
      end
      if (wr_seq) begin
         next_sequence_control = {1'b0, pwdata[6:0]};
      end
      if (wr_access && (paddr == ASC_OFF_MODE)) begin
         next_mode_control = {6'h00, pwdata[1:0]};
      end
      if (setup && !pwrite) begin
         next_rd_data = 32'h0000_0000;
         if (paddr == ASC_OFF_TIMING) begin
            next_rd_data[7:0] = timing_control;
         end else if (paddr == ASC_OFF_SEQ) begin
            next_rd_data[7:0] = sequence_control;
         end else if (paddr == ASC_OFF_MODE) begin
            next_rd_data[7:0] = mode_control;
         end else if (paddr == ASC_OFF_STATUS) begin
            next_rd_data[ASC_STAT_SCF_BIT] = sequence_complete_flag;
            next_rd_data[ASC_STAT_CNT_LSB +: 3] = res_ptr;
            next_rd_data[7:0] = conversion_complete_flags;
         end else if (mapped(paddr)) begin
            next_rd_data[9:0] = result_file[paddr[4:2]];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         timing_control <= ASC_TIMING_RESET;
         sequence_control <= ASC_SEQ_RESET;
         mode_control <= ASC_MODE_RESET;
         rd_data <= 32'h0000_0000;
      end else begin
         timing_control <= next_timing_control;
         sequence_control <= next_sequence_control;
         mode_control <= next_mode_control;
         rd_data <= next_rd_data;
      end
   end

   // ===========================================================
   // result data from the analog side crosses two flip-flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a <= 10'h000;
         sync_b <= 10'h000;
      end else begin
         sync_a <= adc_result_data;
         sync_b <= sync_a;
      end
   end

   // ===========================================================
   // sequencer next values
   always_comb begin
      next_state = state;
      next_phase_cnt = phase_cnt;
      next_seq_pos = seq_pos;
      next_res_ptr = res_ptr;
      next_cur_code = cur_code;
      next_sequence_complete_flag = sequence_complete_flag;
      next_conversion_complete_flags = conversion_complete_flags;
      store_en = 1'b0;
      if (start_seq) begin
         // a start aborts whatever runs; the abort wins over a finishing conversion
         next_state = ASC_BUF;
         next_phase_cnt = 5'h00;
         next_seq_pos = 3'h0;
         next_sequence_complete_flag = 1'b0;
         next_conversion_complete_flags = 8'h00;
         next_cur_code = wr_seq ? pwdata[ASC_CODE_LSB +: 3] : sequence_control[ASC_CODE_LSB +: 3];
         if (!mode_control[ASC_FIFO_BIT]) begin
            next_res_ptr = 3'h0;
         end
      end else if (tick) begin
         unique case (state)
            ASC_IDLE: begin
               next_phase_cnt = 5'h00;
            end
            ASC_BUF: begin
               next_phase_cnt = phase_cnt + 5'h01;
               if (phase_cnt == ASC_BUF_SAMPLE_CLKS - 5'h01) begin
                  next_phase_cnt = 5'h00;
                  next_state = ASC_FINAL;
               end
            end
            ASC_FINAL: begin
               next_phase_cnt = phase_cnt + 5'h01;
               if (phase_cnt == final_clks(timing_control[ASC_SMP_LSB +: 2]) - 5'h01) begin
                  next_phase_cnt = 5'h00;
                  next_state = ASC_CONV;
               end
            end
            ASC_CONV: begin
               next_phase_cnt = phase_cnt + 5'h01;
               if (phase_cnt == conv_clks - 5'h01) begin
                  // reserved special codes run the same timing, result as presented
                  store_en = 1'b1;
                  next_phase_cnt = 5'h00;
                  next_conversion_complete_flags[seq_pos] = 1'b1;
                  next_res_ptr = res_ptr + 3'h1;
                  if (sequence_control[ASC_MULTI_CHANNEL_BIT_BIT]) begin
                     next_cur_code = cur_code + 3'h1;
                  end
                  if (seq_pos == last_pos) begin
                     next_sequence_complete_flag = 1'b1;
                     next_seq_pos = 3'h0;
                     next_cur_code = sequence_control[ASC_CODE_LSB +: 3];
                     if (!mode_control[ASC_FIFO_BIT]) begin
                        next_res_ptr = 3'h0;
                     end
                     next_state = sequence_control[ASC_SCAN_BIT] ? ASC_BUF : ASC_IDLE;
                  end else begin
                     next_seq_pos = seq_pos + 3'h1;
                     next_state = ASC_BUF;
                  end
               end
            end
            default: begin
               next_state = ASC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ASC_IDLE;
         phase_cnt <= 5'h00;
         seq_pos <= 3'h0;
         res_ptr <= 3'h0;
         cur_code <= 3'h0;
         sequence_complete_flag <= 1'b0;
         conversion_complete_flags <= 8'h00;
      end else begin
         state <= next_state;
         phase_cnt <= next_phase_cnt;
         seq_pos <= next_seq_pos;
         res_ptr <= next_res_ptr;
         cur_code <= next_cur_code;
         sequence_complete_flag <= next_sequence_complete_flag;
         conversion_complete_flags <= next_conversion_complete_flags;
      end
   end

   // result storage; 8-bit results sit in the low byte
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 8; i++) begin
            result_file[i] <= 10'h000;
         end
      end else if (store_en) begin
         result_file[res_ptr] <= timing_control[ASC_RES_BIT] ? sync_b :
            {2'b00, sync_b[7:0]};
      end
   end

   // ===========================================================
   // analog side controls, all from flip-flops except the tick
   assign ad_clk_tick = tick;
   assign sample_buffered = (state == ASC_BUF);
   assign sample_final = (state == ASC_FINAL);
   assign convert_active = (state == ASC_CONV);
   assign convert_ten_bit = timing_control[ASC_RES_BIT];
   assign special_channel_bit = sequence_control[ASC_SPECIAL_BIT];
   assign channel_select = cur_code;
   assign sequence_busy = (state != ASC_IDLE);
endmodule // asc_sequencer
`default_nettype wire

// ==== verif/asc_props.sv ====
// checker for the sequencer ports: tick spacing, phase lengths, starts
// assumes register writes land at edges where psel, penable and pready are high
`timescale 1ns/1ns
`default_nettype none
module asc_props
   import asc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [9:0] adc_result_data,
   input wire logic ad_clk_tick,
   input wire logic sample_buffered,
   input wire logic sample_final,
   input wire logic convert_active,
   input wire logic convert_ten_bit,
   input wire logic special_channel_bit,
   input wire logic [2:0] channel_select,
   input wire logic sequence_busy
);
   // ==========================================================
   // shadow fields and tick counters
   logic wr;
   logic st;
   logic armed;
   logic [7:0] tim;
   logic [7:0] sq;
   logic [6:0] gap;
   logic [4:0] nb;
   logic [4:0] nf;
   logic [4:0] nc;
   assign wr = psel & penable & pready & pwrite;
   assign st = wr & (paddr == ASC_OFF_TIMING | paddr == ASC_OFF_SEQ);
   // a start restarts the divider, so the first gap after it is not judged
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tim <= ASC_TIMING_RESET;
         sq <= ASC_SEQ_RESET;
         armed <= 1'b0;
         gap <= 7'h00;
         nb <= 5'h00;
         nf <= 5'h00;
         nc <= 5'h00;
      end else begin
         if (wr && paddr == ASC_OFF_TIMING) tim <= pwdata[7:0];
         if (wr && paddr == ASC_OFF_SEQ) sq <= pwdata[7:0];
         armed <= st ? 1'b0 : (ad_clk_tick | armed);
         gap <= ad_clk_tick ? 7'h01 : (gap == 7'h7F ? gap : gap + 7'h01);
         nb <= (sample_buffered & !st) ? nb + 5'(ad_clk_tick) : 5'h00;
         nf <= (sample_final & !st) ? nf + 5'(ad_clk_tick) : 5'h00;
         nc <= (convert_active & !st) ? nc + 5'(ad_clk_tick) : 5'h00;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   property p_tick;
      ad_clk_tick && armed |-> gap == {1'b0, tim[4:0], 1'b0} + 7'h02;
   endproperty
   a_tick: assert property (p_tick) else $error("tick spacing wrong");
   property p_buf;
      $fell(sample_buffered) && !$past(st) |-> nb == ASC_BUF_SAMPLE_CLKS;
   endproperty
   a_buf: assert property (p_buf) else $error("buffered phase length wrong");
   property p_fin;
      $fell(sample_final) && !$past(st) |-> nf == (ASC_FINAL_2 << tim[6:5]);
   endproperty
   a_fin: assert property (p_fin) else $error("final phase length wrong");
   property p_conv;
      $fell(convert_active) && !$past(st)
         |-> nc == (tim[ASC_RES_BIT] ? ASC_CONV_CLKS_10 : ASC_CONV_CLKS_8);
   endproperty
   a_conv: assert property (p_conv) else $error("conversion length wrong");
   property p_start;
      st |=> sequence_busy && sample_buffered && !sample_final && !convert_active;
   endproperty
   a_start: assert property (p_start) else $error("start did not restart");
   property p_idle;
      $fell(sequence_busy) |-> !sq[ASC_SCAN_BIT];
   endproperty
   a_idle: assert property (p_idle) else $error("scan stopped on its own");
   property p_single;
      convert_active && !sq[ASC_MULTI_CHANNEL_BIT_BIT]
         |-> channel_select == sq[2:0] && special_channel_bit == sq[ASC_SPECIAL_BIT];
   endproperty
   a_single: assert property (p_single) else $error("channel moved");
   // the channel must not move while the converter is mid-approximation
   property p_res;
      convert_active && $past(convert_active)
         |-> convert_ten_bit == tim[ASC_RES_BIT] && $stable(channel_select);
   endproperty
   a_res: assert property (p_res) else $error("resolution wrong");
   c_final: cover property ($fell(sample_final));
   c_abort: cover property (st && convert_active);
   c_done: cover property ($fell(sequence_busy));
endmodule // asc_props
bind asc_sequencer asc_props u_asc_props (
   .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .adc_result_data(adc_result_data),
   .ad_clk_tick(ad_clk_tick), .sample_buffered(sample_buffered),
   .sample_final(sample_final), .convert_active(convert_active),
   .convert_ten_bit(convert_ten_bit), .special_channel_bit(special_channel_bit),
   .channel_select(channel_select), .sequence_busy(sequence_busy)
);
`default_nettype wire

// ==== verif/asc_analog_model.sv ====
// analog side model: a channel dependent code while converting
// assumes the sequencer samples the line only during the conversion phase
`timescale 1ns/1ns
`default_nettype none
module asc_analog_model (
   input wire logic convert_active,
   input wire logic convert_ten_bit,
   input wire logic special_channel_bit,
   input wire logic [2:0] channel_select,
   output logic [9:0] adc_result_data
);
   logic [9:0] code;
   // references give full scale, zero and midpoint
   always_comb begin
      if (special_channel_bit) begin
         case (channel_select)
            3'h4: code = convert_ten_bit ? 10'h3FF : 10'h0FF;
            3'h5: code = 10'h000;
            3'h6: code = convert_ten_bit ? 10'h1FF : 10'h07F;
            default: code = 10'h2AA;
         endcase
      end else begin
         code = convert_ten_bit ? {channel_select, 7'h15} : {2'h0, channel_select, 5'h15};
      end
   end
   // outside conversion the line shows the inverse, so a late sample is caught
   assign adc_result_data = convert_active ? code : ~code;
endmodule // asc_analog_model
`default_nettype wire

// ==== verif/adc_sequence_control_tb.sv ====
// testbench for the sequencer: apb tasks, analog model, result and flag checks
// assumes zero wait apb answers and the register map of the package
`timescale 1ns/1ns
`default_nettype none
module adc_sequence_control_tb;
   import asc_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] adc_result_data;
   logic ad_clk_tick;
   logic sample_buffered;
   logic sample_final;
   logic convert_active;
   logic convert_ten_bit;
   logic special_channel_bit;
   logic [2:0] channel_select;
   logic sequence_busy;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int comparisons = 0;
   logic [7:0] tm [4] = '{8'h00, 8'h00, 8'h01, 8'h01};
   logic [7:0] ts [4] = '{8'h16, 8'h43, 8'h55, 8'h02};
   int tn [4] = '{4, 8, 8, 1};
   logic [31:0] sv [3] = '{32'hFF, 32'h00, 32'h7F};
   always #4 sys_clk = ~sys_clk;
   asc_sequencer u_asc_sequencer (
      .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_result_data(adc_result_data),
      .ad_clk_tick(ad_clk_tick), .sample_buffered(sample_buffered),
      .sample_final(sample_final), .convert_active(convert_active),
      .convert_ten_bit(convert_ten_bit), .special_channel_bit(special_channel_bit),
      .channel_select(channel_select), .sequence_busy(sequence_busy));
   asc_analog_model u_asc_analog_model (
      .convert_active(convert_active), .convert_ten_bit(convert_ten_bit),
      .special_channel_bit(special_channel_bit), .channel_select(channel_select),
      .adc_result_data(adc_result_data));
   // ==========================================================
   // helpers
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // request held until pready is seen high at an edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(what, rd, exp);
   endtask
   // the start edge is the one xfer returns on, so look one edge later
   task automatic wait_idle();
      int i;
      @(posedge sys_clk);
      for (i = 0; i < 3000 && sequence_busy !== 1'b0; i++) @(posedge sys_clk);
      if (sequence_busy !== 1'b0) begin
         n_errors++;
         give_verdict();
      end
   endtask
   task automatic run(input logic [7:0] m, input logic [7:0] s);
      xfer(ASC_OFF_MODE, 1'b1, {24'h0, m});
      xfer(ASC_OFF_SEQ, 1'b1, {24'h0, s});
      wait_idle();
   endtask
   function automatic logic [31:0] ev(input logic [2:0] ch, input logic ten);
      ev = ten ? {22'h0, ch, 7'h15} : {24'h0, ch, 5'h15};
   endfunction
   function automatic logic [31:0] stv(input logic [2:0] n, input logic [7:0] f);
      stv = {16'h0, 1'b1, 4'h0, n, f};
   endfunction
   function automatic logic [7:0] ra(input logic [2:0] k);
      ra = ASC_OFF_RESULT0 + {3'h0, k, 2'h0};
   endfunction
   // ==========================================================
   // main sequence
   initial begin
      int k;
      int c;
      logic [2:0] ch;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      rchk("timing", ASC_OFF_TIMING, 32'h01);
      rchk("seq", ASC_OFF_SEQ, 32'h00);
      rchk("status", ASC_OFF_STATUS, 32'h00);
      xfer(8'h10, 1'b0, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      $display("test reset done");
      // every sample time and resolution, prescale kept below 01000
      run(8'h01, 8'h05);
      for (k = 0; k < 8; k++) begin
         xfer(ASC_OFF_TIMING, 1'b1, {24'h0, k[2], k[1:0], 3'h0, k[1:0]});
         wait_idle();
         rchk("res0", ra(3'h0), ev(3'h5, k[2]));
         rchk("stat", ASC_OFF_STATUS, stv(3'h0, 8'h01));
      end
      xfer(ASC_OFF_TIMING, 1'b1, 32'h01);
      wait_idle();
      $display("test timing done");
      for (c = 0; c < 4; c++) begin
         run(tm[c], ts[c]);
         rchk("stat", ASC_OFF_STATUS, stv(3'h0, 8'((1 << tn[c]) - 1)));
         for (k = 0; k < tn[c]; k++) begin
            ch = ts[c][2:0] + (ts[c][4] ? 3'(k) : 3'h0);
            rchk("res", ra(3'(k)), ev(ch, 1'b0));
         end
      end
      $display("test lengths done");
      for (k = 0; k < 4; k++) begin
         run(8'h01, 8'h08 | 8'(k == 3 ? 0 : k + 4));
         rchk("stat", ASC_OFF_STATUS, stv(3'h0, 8'h01));
         if (k < 3) rchk("ref", ra(3'h0), sv[k]);
      end
      $display("test special done");
      for (k = 1; k < 4; k++) run(8'h03, 8'(k));
      for (k = 0; k < 3; k++) rchk("fifo", ra(3'(k)), ev(3'(k + 1), 1'b0));
      run(8'h02, 8'h50);
      rchk("stat", ASC_OFF_STATUS, stv(3'h3, 8'hFF));
      for (k = 0; k < 8; k++) rchk("wrap", ra(3'(k + 3)), ev(3'(k), 1'b0));
      $display("test fifo done");
      xfer(ASC_OFF_MODE, 1'b1, 32'h01);
      xfer(ASC_OFF_SEQ, 1'b1, 32'h24);
      for (k = 0; k < 200 && rd[15] !== 1'b1; k++) xfer(ASC_OFF_STATUS, 1'b0, 32'h0);
      chk("scf", rd, stv(3'h0, 8'h01));
      chk("scan", {31'h0, sequence_busy}, 32'h1);
      xfer(ASC_OFF_TIMING, 1'b1, 32'h01);
      rchk("abort", ASC_OFF_STATUS, 32'h00);
      xfer(ASC_OFF_SEQ, 1'b1, 32'h04);
      wait_idle();
      rchk("stop", ASC_OFF_STATUS, stv(3'h0, 8'h01));
      $display("test scan done");
      give_verdict();
   end
endmodule // adc_sequence_control_tb
`default_nettype wire
